/* File: rtl/twr_pkg.sv */
// shared constants for the two-wire register access link
package twr_pkg;
    localparam logic [6:0] TWR_ADDR_STRAP_LO = 7'h4C;
    localparam logic [6:0] TWR_ADDR_STRAP_HI = 7'h4D;
    localparam int         TWR_FILT_CYCLES   = 3;
    localparam int         TWR_CLK_NS        = 10;
    localparam int         TWR_SCL_PERIOD_NS = 1000;
    localparam int         TWR_SCL_HALF      = TWR_SCL_PERIOD_NS / (2 * TWR_CLK_NS);
    localparam logic [7:0] TWR_PTR_RESET     = 8'h00;
    localparam logic       TWR_DIR_WRITE     = 1'b0;
    localparam logic       TWR_DIR_READ      = 1'b1;
endpackage : twr_pkg

/* File: rtl/twr_link_if.sv */
// two-wire link carrier: open-drain clock and data lines with both ends
`timescale 1ns/1ps
interface twr_link_if;
    logic scl_o;
    logic scl_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda_hst_o;
    logic sda_hst_oe;
    logic scl;
    logic sda;
    // open drain with pull-up: any enabled low driver wins
    assign scl = !(scl_oe && !scl_o);
    assign sda = !((sda_dev_oe && !sda_dev_o) || (sda_hst_oe && !sda_hst_o));
    modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
    modport host   (input scl, input sda, output scl_o, output scl_oe,
                    output sda_hst_o, output sda_hst_oe);
endinterface : twr_link_if

/* File: rtl/twr_device.sv */
// device end: two-wire target with an 8-bit register pointer
// Behaviour
// - answer 0x4C strap low, 0x4D strap high
// - host sends address then direction bit last
// - first written byte sets register index
// - pointer increments after each stored byte
// - pointer increments after each returned byte
// - read begins with write of start index
// - repeated start ends write, awaits address
// - read address then registers from index
// - index alone only sets the pointer
// - acknowledge own matching address
// - clock filtered over three crystal periods
// - sample data on filtered rising clock
// - change read data after filtered falling
`timescale 1ns/1ps
module twr_device
    import twr_pkg::*;
#(
    parameter int FILT = TWR_FILT_CYCLES
)(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // link
    twr_link_if.device       link,
    // strap and register file port
    input  wire logic        addr_sel,
    output logic             wr_stb,
    output logic [7:0]       wr_idx,
    output logic [7:0]       wr_data,
    output logic [7:0]       rd_idx,
    input  wire logic [7:0]  rd_data
);
    typedef enum logic [2:0] {TWR_IDLE, TWR_ADDR, TWR_INDEX, TWR_WDATA, TWR_RDATA,
                              TWR_RACK} twr_dev_state_t;

    twr_dev_state_t state_r;
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic [1:0] strap_sync_r;
    logic [FILT-1:0] scl_hist_r;
    logic       scl_f_r;
    logic       sda_d_r;
    logic [7:0] shift_r;
    logic [3:0] bit_r;
    logic [7:0] ptr_r;
    logic       rw_r;
    logic       ack_phase_r;
    logic       drive_r;
    logic       sda_out_r;
    logic       wr_stb_r;
    logic [7:0] wr_idx_r;
    logic [7:0] wr_data_r;

    // the history needs two stages at least, or short clock pulses slip through
    if (FILT < 2) begin : g_filt_chk
        $error("FILT must be at least 2");
    end

    // register bit put out once the given number of bits has gone
    function automatic logic read_bit(input logic [7:0] data, input logic [3:0] sent);
        read_bit = data[3'd7 - sent[2:0]];
    endfunction : read_bit

    // only the second synchroniser stages feed the protocol logic
    wire scl_s = scl_sync_r[1];
    wire sda_s = sda_sync_r[1];
    wire [6:0] own_addr = strap_sync_r[1] ? TWR_ADDR_STRAP_HI : TWR_ADDR_STRAP_LO;
    // filtered level changes only after four equal samples
    wire scl_all_hi = &{scl_hist_r, scl_s};
    wire scl_all_lo = ~|{scl_hist_r, scl_s};
    wire scl_rise = scl_all_hi && !scl_f_r;
    wire scl_fall = scl_all_lo && scl_f_r;
    // start and stop need the filtered clock high: data moving after a fall is neither
    wire start_c  = scl_f_r && sda_d_r && !sda_s;
    wire stop_c   = scl_f_r && !sda_d_r && sda_s;
    wire [7:0] shift_in = {shift_r[6:0], sda_s};
    wire byte_done = scl_rise && !ack_phase_r && (bit_r == 4'd7);
    wire addr_hit  = shift_in[7:1] == own_addr;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync_r   <= 2'h3;
            sda_sync_r   <= 2'h3;
            strap_sync_r <= 2'h0;
            scl_hist_r   <= '1;
            scl_f_r      <= 1'b1;
            sda_d_r      <= 1'b1;
        end else begin
            scl_sync_r   <= {scl_sync_r[0], link.scl};
            sda_sync_r   <= {sda_sync_r[0], link.sda};
            strap_sync_r <= {strap_sync_r[0], addr_sel};
            scl_hist_r   <= {scl_hist_r[FILT-2:0], scl_s};
            if (scl_all_hi || scl_all_lo) begin
                scl_f_r <= scl_all_hi;
            end
            sda_d_r      <= sda_s;
        end
    end

    // byte engine: the ack phase is tracked apart from the bit count
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= TWR_IDLE;
            shift_r     <= 8'h00;
            bit_r       <= 4'd0;
            ptr_r       <= TWR_PTR_RESET;
            rw_r        <= TWR_DIR_WRITE;
            ack_phase_r <= 1'b0;
            drive_r     <= 1'b0;
            sda_out_r   <= 1'b1;
            wr_stb_r    <= 1'b0;
            wr_idx_r    <= 8'h00;
            wr_data_r   <= 8'h00;
        end else begin
            // the write strobe lasts one cycle
            wr_stb_r <= 1'b0;
            if (start_c) begin
                // a repeated start also closes any write phase
                state_r     <= TWR_ADDR;
                bit_r       <= 4'd0;
                ack_phase_r <= 1'b0;
                drive_r     <= 1'b0;
            end else if (stop_c) begin
                state_r <= TWR_IDLE;
                drive_r <= 1'b0;
            end else if (state_r != TWR_IDLE) begin
                if (scl_rise && !ack_phase_r) begin
                    shift_r <= shift_in;
                    bit_r   <= bit_r + 4'd1;
                end
                if (byte_done) begin
                    ack_phase_r <= 1'b1;
                    unique case (state_r)
                        TWR_ADDR: begin
                            rw_r <= shift_in[0];
                            if (!addr_hit) state_r <= TWR_IDLE;
                        end
                        TWR_INDEX: begin
                            ptr_r   <= shift_in;
                            state_r <= TWR_WDATA;
                        end
                        TWR_WDATA: begin
                            wr_stb_r  <= 1'b1;
                            wr_idx_r  <= ptr_r;
                            wr_data_r <= shift_in;
                            // the pointer wraps from 0xFF to 0x00
                            ptr_r     <= ptr_r + 8'd1;
                        end
                        TWR_RDATA: begin
                            // the pointer moves even if the host then refuses the byte
                            ptr_r   <= ptr_r + 8'd1;
                            state_r <= TWR_RACK;
                        end
                        default: state_r <= TWR_IDLE;
                    endcase
                end else if (ack_phase_r && state_r == TWR_RACK && scl_rise) begin
                    // host nack ends the read; its ack lets the next byte follow
                    state_r <= sda_s ? TWR_IDLE : TWR_RDATA;
                end else if (scl_fall) begin
                    if (ack_phase_r) begin
                        if (state_r == TWR_RACK) begin
                            // eighth read bit ended: free the line for the host's answer
                            drive_r <= 1'b0;
                        end else if (state_r == TWR_RDATA) begin
                            // host acknowledged: put out the top bit of the next register
                            ack_phase_r <= 1'b0;
                            bit_r       <= 4'd0;
                            sda_out_r   <= read_bit(rd_data, 4'd0);
                            drive_r     <= 1'b1;
                        end else if (drive_r) begin
                            // own ack bit just ended
                            ack_phase_r <= 1'b0;
                            bit_r       <= 4'd0;
                            if (state_r == TWR_ADDR) begin
                                state_r <= rw_r ? TWR_RDATA : TWR_INDEX;
                            end
                            if (state_r == TWR_ADDR && rw_r) begin
                                sda_out_r <= read_bit(rd_data, 4'd0);
                                drive_r   <= 1'b1;
                            end else begin
                                drive_r <= 1'b0;
                            end
                        end else begin
                            // drive ack for address, index or write data
                            drive_r   <= 1'b1;
                            sda_out_r <= 1'b0;
                        end
                    end else if (state_r == TWR_RDATA && drive_r) begin
                        // later bits of a read byte, each after a filtered fall
                        sda_out_r <= read_bit(rd_data, bit_r);
                    end
                end
            end
        end
    end

    // read data byte is indexed by the pointer; the pointer holds during a byte
    assign rd_idx          = ptr_r;
    assign wr_stb          = wr_stb_r;
    assign wr_idx          = wr_idx_r;
    assign wr_data         = wr_data_r;
    assign link.sda_dev_o  = sda_out_r;
    assign link.sda_dev_oe = drive_r;
endmodule : twr_device

/* File: rtl/twr_host.sv */
// host end: two-wire master that writes an index, data, or reads back
`timescale 1ns/1ps
module twr_host
    import twr_pkg::*;
#(
    parameter int HALF = TWR_SCL_HALF
)(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // link
    twr_link_if.host         link,
    // user command: one byte op per request
    input  wire logic        req,
    input  wire logic        req_start,
    input  wire logic        req_stop,
    input  wire logic        req_read,
    input  wire logic        req_nack,
    input  wire logic [7:0]  req_data,
    output logic             busy,
    output logic             done,
    output logic             got_ack,
    output logic [7:0]       rsp_data
);
    // below eight the device filter lags the data; above the counter's reach it wraps
    if (HALF < 8 || HALF > 65536) begin : g_half_chk
        $error("HALF out of range for the device filter and counter");
    end
    typedef enum logic [2:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} twr_hst_state_t;
    twr_hst_state_t state_r;
    logic [15:0] cnt_r;
    logic [1:0]  ph_r;
    logic [3:0]  bit_r;
    logic [8:0]  sh_r;
    logic        rd_r, stop_r, scl_r, sda_r, busy_r, done_r, ack_r;
    logic [7:0]  rsp_r;
    logic [1:0]  sda_sync_r;
    wire tick = cnt_r == 16'(HALF - 1);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= HS_IDLE; cnt_r <= 16'h0000; ph_r <= 2'h0; bit_r <= 4'h0;
            sh_r <= 9'h1FF; rd_r <= 1'b0; stop_r <= 1'b0; scl_r <= 1'b1; sda_r <= 1'b1;
            busy_r <= 1'b0; done_r <= 1'b0; ack_r <= 1'b0; rsp_r <= 8'h00;
            sda_sync_r <= 2'h3;
        end else begin
            sda_sync_r <= {sda_sync_r[0], link.sda};
            done_r     <= 1'b0;
            cnt_r      <= tick ? 16'h0000 : cnt_r + 16'h0001;
            unique case (state_r)
                HS_IDLE: if (req) begin
                    busy_r <= 1'b1; rd_r <= req_read; stop_r <= req_stop;
                    // read sends ones plus the ack choice; write sends data then releases
                    sh_r  <= req_read ? {8'hFF, req_nack} : {req_data, 1'b1};
                    bit_r <= 4'h0; ph_r <= 2'h0; cnt_r <= 16'h0000;
                    state_r <= req_start ? HS_START : HS_BIT;
                end
                HS_START: if (tick) begin
                    ph_r <= ph_r + 2'h1;
                    unique case (ph_r)
                        2'h0: begin sda_r <= 1'b1; end
                        2'h1: begin scl_r <= 1'b1; end
                        2'h2: begin sda_r <= 1'b0; end
                        default: begin scl_r <= 1'b0; ph_r <= 2'h0; state_r <= HS_BIT; end
                    endcase
                end
                HS_BIT: if (tick) begin
                    ph_r <= ph_r + 2'h1;
                    unique case (ph_r)
                        2'h0: sda_r <= sh_r[8];
                        2'h1: scl_r <= 1'b1;
                        2'h2: begin
                            if (bit_r == 4'h8) ack_r <= !sda_sync_r[1];
                            else rsp_r <= {rsp_r[6:0], sda_sync_r[1]};
                        end
                        default: begin
                            scl_r <= 1'b0; ph_r <= 2'h0;
                            sh_r  <= {sh_r[7:0], 1'b1};
                            bit_r <= bit_r + 4'h1;
                            if (bit_r == 4'h8) begin
                                if (stop_r) state_r <= HS_STOP;
                                else begin state_r <= HS_IDLE; busy_r <= 1'b0; done_r <= 1'b1; end
                            end
                        end
                    endcase
                end
                HS_STOP: if (tick) begin
                    ph_r <= ph_r + 2'h1;
                    unique case (ph_r)
                        2'h0: sda_r <= 1'b0;
                        2'h1: scl_r <= 1'b1;
                        2'h2: sda_r <= 1'b1;
                        default: begin ph_r <= 2'h0; state_r <= HS_IDLE;
                                       busy_r <= 1'b0; done_r <= 1'b1; end
                    endcase
                end
                default: state_r <= HS_IDLE;
            endcase
        end
    end
    assign link.scl_o      = scl_r;
    assign link.scl_oe     = 1'b1;
    assign link.sda_hst_o  = sda_r;
    assign link.sda_hst_oe = !sda_r;
    assign busy = busy_r;
    assign done = done_r;
    assign got_ack = ack_r;
    assign rsp_data = rsp_r;
endmodule : twr_host

/* File: testbench/twr_link_props.sv */
// checker on the link signals between host and device ends
`timescale 1ns/1ps
module twr_link_props
    import twr_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // link lines
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic sda_hst_o,
    input wire logic sda_hst_oe,
    // strap
    input wire logic addr_sel
);
    logic       scl_r, sda_r, first_r, sel_r, rd_r, nak_r;
    logic [3:0] nbit_r;
    logic [7:0] shf_r;
    wire        dev_low = sda_dev_oe && !sda_dev_o;
    wire        hst_low = sda_hst_oe && !sda_hst_o;
    wire        rise    = scl && !scl_r;
    wire        start   = scl && scl_r && sda_r && !sda;
    wire        ninth   = rise && (nbit_r == 4'h8);
    wire        match   = shf_r[7:1] == (addr_sel ? TWR_ADDR_STRAP_HI : TWR_ADDR_STRAP_LO);
    // raw pin edges are used: host data is settled long before its clock rises
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            {scl_r, sda_r} <= 2'h3;
            {first_r, sel_r, rd_r, nak_r} <= 4'h0;
            nbit_r <= 4'h0;
            shf_r <= 8'h00;
        end else begin
            {scl_r, sda_r} <= {scl, sda};
            if (start) begin
                nbit_r <= 4'h0;
                first_r <= 1'b1;
                nak_r <= 1'b0;
            end else if (rise) begin
                nbit_r <= (nbit_r == 4'h9) ? 4'h1 : nbit_r + 4'h1;
                if (!ninth) shf_r <= {shf_r[6:0], sda};
                if (ninth && first_r) {sel_r, rd_r, first_r} <= {match, match && shf_r[0], 1'b0};
                if (ninth && rd_r && sda) nak_r <= 1'b1;
            end
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_addr_ack: assert property (ninth && first_r |-> sda == !match)
        else $error("address acknowledge does not follow the strap");
    a_wr_ack: assert property (ninth && !first_r && sel_r && !rd_r |-> !sda)
        else $error("written byte not acknowledged");
    a_ack_release: assert property (ninth && dev_low && !first_r && !rd_r |-> ##[1:40] !dev_low)
        else $error("write acknowledge held too long");
    a_nak_release: assert property (nak_r |-> !dev_low)
        else $error("device drives data after host nack");
    a_addr_listen: assert property (rise && first_r && !ninth |-> !dev_low)
        else $error("device drives data during an address byte");
    a_rd_host_off: assert property (rise && rd_r && !first_r && !ninth && !nak_r |-> !hst_low)
        else $error("host drives data during a read byte");
    a_edge_delay: assert property ($changed(dev_low) |-> !$past(scl) && !$past(scl, 2) && !$past(scl, 3))
        else $error("device data changed too soon after clock fall");
    a_hold_high: assert property (scl && $past(scl) |-> $stable(dev_low))
        else $error("device data changed while clock high");
endmodule : twr_link_props

/* File: testbench/two_wire_register_access_slave_tb_top.sv */
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
module two_wire_register_access_slave_tb_top
    import twr_pkg::*;
;
    logic        ref_clk, rst_n, addr_sel, scl_q;
    logic        req, req_start, req_stop, req_read, req_nack;
    logic [7:0]  req_data, rsp_data, wr_idx, wr_data, rd_idx, rd_data;
    logic        busy, done, got_ack, wr_stb;
    logic [8:0]  wire_sh;
    logic [15:0] wq[$];
    int          num_errors = 0;
    int          num_checks = 0;
    twr_link_if lnk ();
    // register contents seen by reads: a fixed pattern of the index
    assign rd_data = rd_idx ^ 8'h5A;
    twr_host #(.HALF(8)) u_twr_host (.ref_clk(ref_clk), .rst_n(rst_n), .link(lnk),
        .req(req), .req_start(req_start), .req_stop(req_stop), .req_read(req_read),
        .req_nack(req_nack), .req_data(req_data), .busy(busy), .done(done),
        .got_ack(got_ack), .rsp_data(rsp_data));
    twr_device u_twr_device (.ref_clk(ref_clk), .rst_n(rst_n), .link(lnk), .addr_sel(addr_sel),
        .wr_stb(wr_stb), .wr_idx(wr_idx), .wr_data(wr_data), .rd_idx(rd_idx), .rd_data(rd_data));
    twr_link_props u_twr_link_props (.ref_clk(ref_clk), .rst_n(rst_n), .scl(lnk.scl),
        .sda(lnk.sda), .sda_dev_o(lnk.sda_dev_o), .sda_dev_oe(lnk.sda_dev_oe),
        .sda_hst_o(lnk.sda_hst_o), .sda_hst_oe(lnk.sda_hst_oe), .addr_sel(addr_sel));
    // wire monitor: last nine bits seen at clock rises, and register writes
    always @(posedge ref_clk) begin
        scl_q <= lnk.scl;
        if (lnk.scl && !scl_q) wire_sh <= {wire_sh[7:0], lnk.sda};
        if (wr_stb === 1'b1) wq.push_back({wr_idx, wr_data});
    end
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // f = {start, stop, read, nack}; d is the byte sent or the byte expected back
    task automatic op(input logic [3:0] f, input logic [7:0] d, input logic ack);
        int n;
        @(posedge ref_clk);
        {req, req_start, req_stop, req_read, req_nack, req_data} <= {1'b1, f, d};
        @(posedge ref_clk);
        req <= 1'b0;
        #1;
        for (n = 0; n < 2000 && done !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
        end
        if (n == 2000) begin
            num_errors++;
            report_and_stop();
        end else begin
            if (f[1]) chk({8'h00, rsp_data}, {8'h00, d});
            else chk({15'h0000, got_ack}, {15'h0000, ack});
            // a stop adds a clock rise, so the wire view is only taken mid-transfer
            if (!f[2]) chk({7'h00, wire_sh}, {7'h00, d, f[1] ? f[0] : !ack});
        end
    endtask : op
    task automatic t_write();
        int i;
        wq.delete();
        op(4'h8, {TWR_ADDR_STRAP_LO, TWR_DIR_WRITE}, 1'b1);
        op(4'h0, 8'hFE, 1'b1);
        for (i = 0; i < 3; i++) op(i == 2 ? 4'h4 : 4'h0, 8'(17 * (i + 1)), 1'b1);
        chk(16'(wq.size()), 16'h0003);
        for (i = 0; i < 3 && i < wq.size(); i++) chk(wq[i], {8'hFE + 8'(i), 8'(17 * (i + 1))});
        $display("write burst test finished");
    endtask : t_write
    task automatic t_read();
        int i;
        wq.delete();
        op(4'h8, {TWR_ADDR_STRAP_LO, TWR_DIR_WRITE}, 1'b1);
        op(4'h0, 8'h10, 1'b1);
        op(4'h8, {TWR_ADDR_STRAP_LO, TWR_DIR_READ}, 1'b1);
        for (i = 0; i < 3; i++) op(i == 2 ? 4'h7 : 4'h2, 8'(8'h10 + i) ^ 8'h5A, 1'b0);
        chk(16'(wq.size()), 16'h0000);
        chk({8'h00, rd_idx}, 16'h0013);
        $display("read burst test finished");
    endtask : t_read
    task automatic t_index_only();
        wq.delete();
        op(4'h8, {TWR_ADDR_STRAP_LO, TWR_DIR_WRITE}, 1'b1);
        op(4'h4, 8'h40, 1'b1);
        op(4'h8, {TWR_ADDR_STRAP_LO, TWR_DIR_READ}, 1'b1);
        op(4'h7, 8'h40 ^ 8'h5A, 1'b0);
        chk(16'(wq.size()), 16'h0000);
        $display("index only test finished");
    endtask : t_index_only
    task automatic t_strap();
        int s;
        for (s = 0; s < 4; s++) begin
            addr_sel <= s[1];
            repeat (6) @(posedge ref_clk);
            op(4'hC, {s[0] ? TWR_ADDR_STRAP_HI : TWR_ADDR_STRAP_LO, TWR_DIR_WRITE}, s[0] == s[1]);
        end
        addr_sel <= 1'b0;
        $display("strap test finished");
    endtask : t_strap
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        {rst_n, addr_sel, req, req_start, req_stop, req_read, req_nack} = 7'h00;
        req_data = 8'h00;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        t_write();
        t_read();
        t_index_only();
        t_strap();
        report_and_stop();
    end
endmodule : two_wire_register_access_slave_tb_top
